// ### common/incl_pkg.sv
package incl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          REF_CLK_PERIOD_NS = 5;
  localparam int          GAP_TIME_NS       = 10000;
  localparam int          GAP_CYC           = (GAP_TIME_NS + REF_CLK_PERIOD_NS - 1)
                                              / REF_CLK_PERIOD_NS;
  localparam logic [11:0] GAP_CNT_MAX       = 12'(GAP_CYC);
  localparam logic [2:0]  SCLK_HALF_LAST    = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam int FRAME_RW_BIT   = 31;
  localparam int FRAME_ADDR_LSB = 26;
  localparam int FRAME_RS_LSB   = 24;
  localparam int FRAME_DATA_LSB = 8;

  localparam logic [1:0] RS_NORMAL = 2'h1;
  localparam logic [1:0] RS_ERROR  = 2'h3;

  localparam logic [7:0] CRC_SEED = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_XOR  = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // device register addresses
  localparam logic [4:0] ADDR_COMPONENT_ID      = 5'h10;
  localparam logic [4:0] ADDR_SERIAL_NUMBER_LOW = 5'h19;
  localparam logic [4:0] ADDR_SERIAL_NUMBER_HIGH = 5'h1a;
  localparam logic [4:0] ADDR_ACTIVE_BANK_SELECT = 5'h1f;
  localparam logic [4:0] ADDR_ANGLE_OUT         = 5'h09;

  // identity and serial values are arbitrary
  localparam logic [7:0]  COMPONENT_ID_VALUE = 8'h5a;
  localparam logic [15:0] SERIAL_LOW_VALUE   = 16'h1234;
  localparam logic [15:0] SERIAL_HIGH_VALUE  = 16'habcd;

  localparam logic        BANK_RESET     = 1'b0;
  localparam logic [4:0]  ANGLE_EN_RESET = 5'h00;
  localparam logic [4:0]  ANGLE_EN_ALL   = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // fixed frames
  localparam logic [31:0] FRAME_READ_ID        = 32'h40000091;
  localparam logic [31:0] FRAME_READ_SER_LOW   = 32'h640000a7;
  localparam logic [31:0] FRAME_READ_SER_HIGH  = 32'h680000ad;
  localparam logic [31:0] FRAME_READ_BANK      = 32'h7c0000b3;
  localparam logic [31:0] FRAME_SEL_LOWER_BANK = 32'hfc000073;
  localparam logic [31:0] FRAME_SEL_UPPER_BANK = 32'hfc00016e;
  localparam logic [31:0] FRAME_ANGLE_ENABLE   = 32'hb0001f6f;
  localparam logic [31:0] FRAME_SW_RESET       = 32'hb4002098;

  ////////////////////////////////////////////////////////////////////////////
  // host command port map
  localparam logic [3:0] HOST_CONTROL_OFS   = 4'h0;
  localparam logic [3:0] HOST_ID_OFS        = 4'h1;
  localparam logic [3:0] HOST_SERIAL_OFS    = 4'h2;
  localparam logic [3:0] HOST_LAST_RESP_OFS = 4'h3;

  localparam logic [1:0] OP_NONE      = 2'h0;
  localparam logic [1:0] OP_ID_CHECK  = 2'h1;
  localparam logic [1:0] OP_SERIAL    = 2'h2;
  localparam logic [1:0] OP_ANGLE_EN  = 2'h3;

endpackage

// ### common/spi_link_if.sv
`timescale 1ns/100ps
interface spi_link_if;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso;

  modport host (output sclk, output chip_select_n, output mosi, input miso);
  modport dev  (input sclk, input chip_select_n, input mosi, output miso);
endinterface

// ### src/incl_sensor_end.sv
`timescale 1ns/100ps
module incl_sensor_end (
  // link
  spi_link_if.dev          LINK,
  // reset, synchronous to the link clock
  input  wire logic        SRST_IN,
  // user side
  input  wire logic [15:0] ANGLE_IN,
  output logic             BANK_OUT,
  output logic [4:0]       ANGLE_EN_OUT
);
  import incl_pkg::*;

  typedef struct packed {
    logic [4:0]  bit_cnt;
    logic [31:0] rx;
    logic [31:0] tx;
    logic        bank;
    logic [4:0]  ang_en;
  } dev_regs_t;

  dev_regs_t r_reg;
  dev_regs_t r_next;
  logic [31:0] frame;
  logic [23:0] hdr;
  logic [1:0]  rs;
  logic [15:0] data;

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--)
    begin
      if (c[7] ^ d[i])
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    return c ^ CRC_XOR;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // no resync on an aborted frame: the bit count relies on whole frames
  always_comb
  begin
    r_next = r_reg;
    frame  = {r_reg.rx[30:0], LINK.mosi};
    rs     = RS_NORMAL;
    data   = 16'h0000;
    hdr    = 24'h000000;
    if (!LINK.chip_select_n)
    begin
      r_next.rx      = frame;
      r_next.tx      = {r_reg.tx[30:0], 1'b0};
      r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
      if (r_reg.bit_cnt == 5'h1f)
      begin
        if (frame == FRAME_SW_RESET)
        begin
          r_next.bank   = BANK_RESET;
          r_next.ang_en = ANGLE_EN_RESET;
        end
        else if (frame == FRAME_SEL_LOWER_BANK)
        begin
          r_next.bank = 1'b0;
          data        = 16'h0000;
        end
        else if (frame == FRAME_SEL_UPPER_BANK)
        begin
          r_next.bank = 1'b1;
          data        = 16'h0001;
        end
        else if (frame == FRAME_READ_BANK)
          data = {15'h0000, r_reg.bank};
        else if (frame == FRAME_READ_ID && !r_reg.bank)
          data = {8'h00, COMPONENT_ID_VALUE};
        else if (frame == FRAME_READ_SER_LOW && r_reg.bank)
          data = SERIAL_LOW_VALUE;
        else if (frame == FRAME_READ_SER_HIGH && r_reg.bank)
          data = SERIAL_HIGH_VALUE;
        else if (frame == FRAME_ANGLE_ENABLE && !r_reg.bank)
        begin
          r_next.ang_en = ANGLE_EN_ALL;
          data          = {11'h000, ANGLE_EN_ALL};
        end
        else if (!frame[FRAME_RW_BIT] && !r_reg.bank
                 && frame[FRAME_ADDR_LSB +: 5] == ADDR_ANGLE_OUT
                 && frame[7:0] == crc8(frame[31:8]))
          data = (r_reg.ang_en == ANGLE_EN_ALL) ? ANGLE_IN : 16'h0000;
        else
          rs = RS_ERROR;
        // reply leaves on the next frame
        hdr       = {frame[31:FRAME_ADDR_LSB], rs, data};
        r_next.tx = {hdr, crc8(hdr)};
      end
    end
  end

  always_ff @(posedge LINK.sclk)
  begin
    if (SRST_IN)
    begin
      r_reg.bit_cnt <= 5'h00;
      r_reg.rx      <= 32'h00000000;
      r_reg.tx      <= 32'h00000000;
      r_reg.bank    <= BANK_RESET;
      r_reg.ang_en  <= ANGLE_EN_RESET;
    end
    else
      r_reg <= r_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  assign LINK.miso    = r_reg.tx[31];
  assign BANK_OUT     = r_reg.bank;
  assign ANGLE_EN_OUT = r_reg.ang_en;
endmodule

// ### src/incl_host_end.sv
`timescale 1ns/100ps
module incl_host_end (
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        SRST_IN,
  // command port
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic [31:0]      RDATA_OUT,
  // link
  spi_link_if.host         LINK
);
  import incl_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE,
    S_WAIT,
    S_XFER,
    S_DONE
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [1:0]  op;
    logic [1:0]  step;
    logic [11:0] gap_cnt;
    logic [2:0]  ph;
    logic [4:0]  bit_idx;
    logic        sclk;
    logic        cs_n;
    logic [31:0] tx;
    logic [31:0] rx;
    logic        miso_meta;
    logic        miso_sync;
    logic [7:0]  id;
    logic        id_ok;
    logic        ang_done;
    logic [15:0] ser_lo;
    logic [15:0] ser_hi;
    logic [31:0] last_resp;
    logic [31:0] rdata;
  } host_regs_t;

  host_regs_t r_reg;
  host_regs_t r_next;
  logic       rs_ok;

  //////////////////////////////////////////////////////////////////////////////
  // frame sequences; id check and angle enable end with a frame that only collects a reply, serial ends with the lower bank select
  function automatic logic [31:0] frame_of(input logic [1:0] op, input logic [1:0] step);
    logic [31:0] f;
    f = FRAME_READ_BANK;
    case (op)
      OP_ID_CHECK:
        if (step == 2'h0)
          f = FRAME_READ_ID;
      OP_SERIAL:
        case (step)
          2'h0:    f = FRAME_SEL_UPPER_BANK;
          2'h1:    f = FRAME_READ_SER_LOW;
          2'h2:    f = FRAME_READ_SER_HIGH;
          default: f = FRAME_SEL_LOWER_BANK;
        endcase
      OP_ANGLE_EN:
        if (step == 2'h0)
          f = FRAME_ANGLE_ENABLE;
      default:
        f = FRAME_READ_BANK;
    endcase
    return f;
  endfunction

  function automatic logic [1:0] last_step(input logic [1:0] op);
    return (op == OP_SERIAL) ? 2'h3 : 2'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    r_next           = r_reg;
    r_next.miso_meta = LINK.miso;
    r_next.miso_sync = r_reg.miso_meta;
    r_next.rdata     = 32'h00000000;
    rs_ok            = (r_reg.rx[FRAME_RS_LSB +: 2] == RS_NORMAL);

    // gap counted only while chip select is high
    if (r_reg.cs_n && r_reg.gap_cnt != GAP_CNT_MAX)
      r_next.gap_cnt = r_reg.gap_cnt + 12'h001;

    // command port reads
    if (RD_IN)
    begin
      if (ADDR_IN == HOST_CONTROL_OFS)
        r_next.rdata = {29'h00000000, r_reg.ang_done, r_reg.id_ok,
                        r_reg.state != S_IDLE};
      else if (ADDR_IN == HOST_ID_OFS)
        r_next.rdata = {24'h000000, r_reg.id};
      else if (ADDR_IN == HOST_SERIAL_OFS)
        r_next.rdata = {r_reg.ser_hi, r_reg.ser_lo};
      else if (ADDR_IN == HOST_LAST_RESP_OFS)
        r_next.rdata = r_reg.last_resp;
      else
        r_next.rdata = 32'h00000000;
    end

    case (r_reg.state)
      S_IDLE:
      begin
        // writes while busy are ignored
        if (WR_IN && ADDR_IN == HOST_CONTROL_OFS && WDATA_IN[1:0] != OP_NONE)
        begin
          r_next.op    = WDATA_IN[1:0];
          r_next.step  = 2'h0;
          r_next.state = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (r_reg.gap_cnt == GAP_CNT_MAX)
        begin
          r_next.cs_n    = 1'b0;
          r_next.sclk    = 1'b0;
          r_next.ph      = 3'h0;
          r_next.bit_idx = 5'h00;
          r_next.tx      = frame_of(r_reg.op, r_reg.step);
          r_next.state   = S_XFER;
        end
      end
      S_XFER:
      begin
        if (r_reg.ph == SCLK_HALF_LAST)
        begin
          r_next.ph = 3'h0;
          if (!r_reg.sclk)
          begin
            // sample just before the rising edge
            r_next.sclk = 1'b1;
            r_next.rx   = {r_reg.rx[30:0], r_reg.miso_sync};
          end
          else
          begin
            r_next.sclk = 1'b0;
            if (r_reg.bit_idx == 5'h1f)
            begin
              r_next.cs_n    = 1'b1;
              r_next.gap_cnt = 12'h000;
              r_next.state   = S_DONE;
            end
            else
            begin
              r_next.bit_idx = r_reg.bit_idx + 5'h01;
              r_next.tx      = {r_reg.tx[30:0], 1'b0};
            end
          end
        end
        else
          r_next.ph = r_reg.ph + 3'h1;
      end
      S_DONE:
      begin
        // reply in rx belongs to the previous frame
        r_next.last_resp = r_reg.rx;
        if (r_reg.op == OP_ID_CHECK && r_reg.step == 2'h1)
        begin
          r_next.id    = r_reg.rx[FRAME_DATA_LSB +: 8];
          r_next.id_ok = rs_ok
                         && r_reg.rx[FRAME_DATA_LSB +: 8] == COMPONENT_ID_VALUE;
        end
        if (r_reg.op == OP_SERIAL && r_reg.step == 2'h2)
          r_next.ser_lo = r_reg.rx[FRAME_DATA_LSB +: 16];
        if (r_reg.op == OP_SERIAL && r_reg.step == 2'h3)
          r_next.ser_hi = r_reg.rx[FRAME_DATA_LSB +: 16];
        if (r_reg.op == OP_ANGLE_EN && r_reg.step == 2'h1)
          r_next.ang_done = rs_ok;
        if (r_reg.step == last_step(r_reg.op))
          r_next.state = S_IDLE;
        else
        begin
          r_next.step  = r_reg.step + 2'h1;
          r_next.state = S_WAIT;
        end
      end
      default:
        r_next.state = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      r_reg.state     <= S_IDLE;
      r_reg.op        <= OP_NONE;
      r_reg.step      <= 2'h0;
      r_reg.gap_cnt   <= 12'h000;
      r_reg.ph        <= 3'h0;
      r_reg.bit_idx   <= 5'h00;
      r_reg.sclk      <= 1'b0;
      r_reg.cs_n      <= 1'b1;
      r_reg.tx        <= 32'h00000000;
      r_reg.rx        <= 32'h00000000;
      r_reg.miso_meta <= 1'b0;
      r_reg.miso_sync <= 1'b0;
      r_reg.id        <= 8'h00;
      r_reg.id_ok     <= 1'b0;
      r_reg.ang_done  <= 1'b0;
      r_reg.ser_lo    <= 16'h0000;
      r_reg.ser_hi    <= 16'h0000;
      r_reg.last_resp <= 32'h00000000;
      r_reg.rdata     <= 32'h00000000;
    end
    else
      r_reg <= r_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  assign LINK.sclk          = r_reg.sclk;
  assign LINK.chip_select_n = r_reg.cs_n;
  assign LINK.mosi          = r_reg.tx[31];
  assign RDATA_OUT          = r_reg.rdata;
endmodule

// ### verif/incl_link_chk.sv
`timescale 1ns/100ps
module incl_link_chk (
  // host clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  // link
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso
);
  import incl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers: gap length in host clock cycles, bits per frame as link clock rises
  logic [11:0] gap_reg;
  logic [5:0]  bits_reg;
  logic        sclk_reg;

  always_ff @(posedge REF_CLK_IN)
  begin
    sclk_reg <= sclk;
    if (SRST_IN || !chip_select_n)
      gap_reg <= 12'h000;
    else if (gap_reg != 12'hfff)
      gap_reg <= gap_reg + 12'h001;
    if (SRST_IN || chip_select_n)
      bits_reg <= 6'h00;
    else if (sclk && !sclk_reg)
      bits_reg <= bits_reg + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link is sampled on the host clock; every link signal comes from a flop
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  a_gap_min_len: assert property ($fell(chip_select_n) |-> gap_reg >= GAP_CYC)
    else $error("chip select gap too short");
  // a rise out of the unknown level before the first reset edge is no frame end
  a_frame_bit_count: assert property ($rose(chip_select_n) && !$past(SRST_IN)
                                      |-> bits_reg == 6'h20)
    else $error("frame did not hold 32 clock rises");
  a_sclk_idle_low: assert property (chip_select_n |-> !sclk)
    else $error("link clock moves outside a frame");
  a_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high phase not 4 cycles");
  a_low_half: assert property (($fell(sclk) || $fell(chip_select_n)) && !chip_select_n
                               |-> !sclk[*4] ##1 sclk)
    else $error("link clock low phase not 4 cycles");
  a_mosi_at_fall: assert property (!chip_select_n && !$past(chip_select_n) && $changed(mosi)
                                   |-> $fell(sclk))
    else $error("host data moved away from clock fall");
  a_miso_at_rise: assert property ($changed(miso) |-> $rose(sclk))
    else $error("device data moved away from clock rise");
  a_reset_idle: assert property ($fell(SRST_IN) |-> chip_select_n && !sclk && !mosi)
    else $error("link not idle after reset");

  c_frame_start: cover property ($fell(chip_select_n));
  c_frame_end: cover property ($rose(chip_select_n) && bits_reg == 6'h20);
  c_gap_tight: cover property ($fell(chip_select_n) && gap_reg < 12'h7e0);
endmodule

// ### verif/tb.sv
`timescale 1ns/100ps
module tb;
  import incl_pkg::*;

  logic        ref_clk;
  logic        srst;
  logic        dev_srst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        bank;
  logic [4:0]  angle_en;
  logic        saw_bank1;
  logic [31:0] v;
  int          n_mismatch;
  int          checks_done;

  spi_link_if link ();
  incl_host_end incl_host_end_i (.REF_CLK_IN(ref_clk), .SRST_IN(srst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LINK(link));
  incl_sensor_end incl_sensor_end_i (.LINK(link), .SRST_IN(dev_srst),
    .ANGLE_IN(16'h2468), .BANK_OUT(bank), .ANGLE_EN_OUT(angle_en));
  incl_link_chk incl_link_chk_i (.REF_CLK_IN(ref_clk), .SRST_IN(srst), .sclk(link.sclk),
    .chip_select_n(link.chip_select_n), .mosi(link.mosi), .miso(link.miso));

  ////////////////////////////////////////////////////////////////////////////
  // expected replies built here, independent of the design
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    logic       b;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--)
    begin
      b = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (b)
        c = c ^ CRC_POLY;
    end
    return c ^ CRC_XOR;
  endfunction

  function automatic logic [31:0] reply(input logic [31:0] req, input logic [15:0] d);
    logic [23:0] h;
    h = {req[31:26], RS_NORMAL, d};
    return {h, crc8(h)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // bounded poll of busy; a hang ends the run
  task automatic wait_idle();
    logic [31:0] s;
    int          i;
    i = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && i < 8000)
    begin
      rd_reg(HOST_CONTROL_OFS, s);
      saw_bank1 = saw_bank1 | bank;
      i++;
    end
    if (s[0] !== 1'b0)
    begin
      n_mismatch++;
      $display("[ERR] %0t operation never finished", $time);
      end_sim();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    srst        = 1'b1;
    dev_srst    = 1'b1;
    addr        = 4'h0;
    wdata       = 32'h0;
    wr          = 1'b0;
    rd          = 1'b0;
    saw_bank1   = 1'b0;
    n_mismatch  = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    // reset values, unmapped read, op 0 refused
    wr_reg(HOST_CONTROL_OFS, {30'h0, OP_NONE});
    rd_reg(HOST_CONTROL_OFS, v);
    chk(v, 32'h0);
    rd_reg(HOST_ID_OFS, v);
    chk(v, 32'h0);
    rd_reg(HOST_SERIAL_OFS, v);
    chk(v, 32'h0);
    rd_reg(4'h7, v);
    chk(v, 32'h0);
    @(posedge ref_clk);
    #1;
    chk(rdata, 32'h0);
    $display("test reset done");
    // device reset needs link clock edges: hold it through one full operation
    wr_reg(HOST_CONTROL_OFS, {30'h0, OP_ID_CHECK});
    wait_idle();
    dev_srst <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, bank}, 32'h0);
    chk({27'h0, angle_en}, {27'h0, ANGLE_EN_RESET});
    // identity check, second order while busy must be ignored
    wr_reg(HOST_CONTROL_OFS, {30'h0, OP_ID_CHECK});
    wr_reg(HOST_CONTROL_OFS, {30'h0, OP_SERIAL});
    wait_idle();
    rd_reg(HOST_CONTROL_OFS, v);
    chk({30'h0, v[1:0]}, 32'h2);
    rd_reg(HOST_ID_OFS, v);
    chk(v, {24'h0, COMPONENT_ID_VALUE});
    rd_reg(HOST_SERIAL_OFS, v);
    chk(v, 32'h0);
    rd_reg(HOST_LAST_RESP_OFS, v);
    chk(v, reply(FRAME_READ_ID, {8'h00, COMPONENT_ID_VALUE}));
    $display("test identity done");
    // serial read walks through bank 1 and back
    saw_bank1 = 1'b0;
    wr_reg(HOST_CONTROL_OFS, {30'h0, OP_SERIAL});
    wait_idle();
    chk({31'h0, saw_bank1}, 32'h1);
    rd_reg(HOST_SERIAL_OFS, v);
    chk(v, {SERIAL_HIGH_VALUE, SERIAL_LOW_VALUE});
    rd_reg(HOST_LAST_RESP_OFS, v);
    chk(v, reply(FRAME_READ_SER_HIGH, SERIAL_HIGH_VALUE));
    chk({31'h0, bank}, 32'h0);
    $display("test serial done");
    // angle enable
    wr_reg(HOST_CONTROL_OFS, {30'h0, OP_ANGLE_EN});
    wait_idle();
    rd_reg(HOST_CONTROL_OFS, v);
    chk({31'h0, v[2]}, 32'h1);
    chk({27'h0, angle_en}, {27'h0, ANGLE_EN_ALL});
    rd_reg(HOST_LAST_RESP_OFS, v);
    chk(v, reply(FRAME_ANGLE_ENABLE, {11'h000, ANGLE_EN_ALL}));
    $display("test angle enable done");
    end_sim();
  end
endmodule
